// ==== tsc_map.svh ====
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Command codes
`define TSC_CMD_READ_TEMP     8'hAA
`define TSC_CMD_READ_COUNTER  8'hA8
`define TSC_CMD_READ_SLOPE    8'hA9
`define TSC_CMD_START_CONV    8'hEE
`define TSC_CMD_STOP_CONV     8'h22
`define TSC_CMD_HIGH_LIMIT    8'hA1
`define TSC_CMD_LOW_LIMIT     8'hA2
`define TSC_CMD_CONFIG        8'hAC

// Address byte layout
`define TSC_CTRL_CODE         4'h9
`define TSC_ADDR_CODE_MSB     7
`define TSC_ADDR_CODE_LSB     4
`define TSC_ADDR_SEL_MSB      3
`define TSC_ADDR_SEL_LSB      1
`define TSC_ADDR_RW_BIT       0

// Configuration byte fields
`define TSC_CFG_ONESHOT_BIT   0
`define TSC_CFG_POL_BIT       1
`define TSC_CFG_NVB_BIT       4
`define TSC_CFG_DONE_BIT      7
`define TSC_CFG_RESET         2'h0

// Reset values and the idle read byte
`define TSC_LIMIT_RESET       16'h0000
`define TSC_TEMP_RESET        16'h0000
`define TSC_IDLE_BYTE         8'hFF

// Nonvolatile write time and clock rate
`define TSC_NV_WRITE_MS       10
`define TSC_CLK_KHZ           125000

`endif

// ==== tsc_pkg.sv ====
package tsc_pkg;

	typedef enum logic [2:0] {
		TSC_IDLE,
		TSC_RECV,
		TSC_ACK,
		TSC_SEND,
		TSC_MACK
	} tsc_state_t;

endpackage

// ==== tsc_sync.sv ====
`timescale 1ns/10ps

// Two-stage synchroniser for pin inputs
module tsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			stage1_reg <= '1;
			syncOut    <= '1;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule

// ==== tsc_command_decoder.sv ====
`timescale 1ns/10ps
`include "tsc_map.svh"

module tsc_command_decoder
	import tsc_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = `TSC_NV_WRITE_MS * `TSC_CLK_KHZ
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic [2:0]  addrSel,
	input  wire logic        convDone,
	input  wire logic [15:0] tempResult,
	input  wire logic [7:0]  countRemain,
	input  wire logic [7:0]  countPerC,
	output logic             convEnable,
	output logic [15:0]      highLimit,
	output logic [15:0]      lowLimit,
	output logic             cfgPolarity,
	output logic             cfgOneShot,
	output logic             nvBusy
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and bus condition detection

	logic [4:0]  syncVec;
	logic        sclS;
	logic        sdaS;
	logic [2:0]  selS;
	logic        sclPrev_reg;
	logic        sdaPrev_reg;

	tsc_sync #(
		.WIDTH(5)
	) u_sync (
		.clock  (clock),
		.srst   (srst),
		.asyncIn({sclIn, sdaIn, addrSel}),
		.syncOut(syncVec)
	);

	assign sclS = syncVec[4];
	assign sdaS = syncVec[3];
	assign selS = syncVec[2:0];

	always_ff @(posedge clock) begin
		if (srst) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= sclS;
			sdaPrev_reg <= sdaS;
		end
	end

	wire sclRise   = sclS & ~sclPrev_reg;
	wire sclFall   = ~sclS & sclPrev_reg;
	wire startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
	wire stopCond  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

	////////////////////////////////////////////////////////////////////////
	// Byte engine state

	tsc_state_t  state_reg;
	tsc_state_t  state_next;
	logic [2:0]  bitCnt_reg;
	logic [7:0]  shift_reg;
	logic        gotByte_reg;
	logic [1:0]  byteIdx_reg;
	logic        readMode_reg;
	logic [7:0]  cmd_reg;
	logic [7:0]  msbHold_reg;
	logic        rdIdx_reg;
	logic        mackOk_reg;
	logic [7:0]  txByte_reg;
	logic        sdaOe_reg;

	// Address match on the received control byte
	wire [7:0] rxByte    = shift_reg;
	wire       addrMatch = (rxByte[`TSC_ADDR_CODE_MSB:`TSC_ADDR_CODE_LSB] == `TSC_CTRL_CODE) &&
	                       (rxByte[`TSC_ADDR_SEL_MSB:`TSC_ADDR_SEL_LSB] == selS);
	wire       byteEnd   = (state_reg == TSC_RECV) && gotByte_reg && sclFall;
	wire       addrByte  = byteEnd && (byteIdx_reg == 2'd0);
	wire       ackAddr   = addrByte && addrMatch;
	wire       dataByte  = byteEnd && (byteIdx_reg != 2'd0) && !readMode_reg;
	wire       cmdByte   = dataByte && (byteIdx_reg == 2'd1);
	wire       wrByte1   = dataByte && (byteIdx_reg == 2'd2);
	wire       wrByte2   = dataByte && (byteIdx_reg == 2'd3);
	wire       ackEnd    = (state_reg == TSC_ACK) && sclFall;
	wire       sendEnd   = (state_reg == TSC_SEND) && sclFall && (bitCnt_reg == 3'd7);
	wire       mackEnd   = (state_reg == TSC_MACK) && sclFall;
	wire       loadTx    = (ackEnd && readMode_reg) || (mackEnd && mackOk_reg);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TSC_IDLE: begin
				state_next = TSC_IDLE;
			end
			TSC_RECV: begin
				if (addrByte) begin
					state_next = addrMatch ? TSC_ACK : TSC_IDLE;
				end else if (byteEnd) begin
					state_next = TSC_ACK;
				end
			end
			TSC_ACK: begin
				if (ackEnd) begin
					state_next = readMode_reg ? TSC_SEND : TSC_RECV;
				end
			end
			TSC_SEND: begin
				if (sendEnd) begin
					state_next = TSC_MACK;
				end
			end
			TSC_MACK: begin
				if (sclRise && sdaS) begin
					state_next = TSC_IDLE;
				end else if (mackEnd) begin
					state_next = mackOk_reg ? TSC_SEND : TSC_IDLE;
				end
			end
			default: begin
				state_next = TSC_IDLE;
			end
		endcase
		if (startCond) begin
			state_next = TSC_RECV;
		end else if (stopCond) begin
			state_next = TSC_IDLE;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= TSC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Receive shifter and bit counter
	always_ff @(posedge clock) begin
		if (srst || startCond || ackEnd || loadTx) begin
			bitCnt_reg  <= 3'd0;
			gotByte_reg <= 1'b0;
		end else if (state_reg == TSC_RECV && sclRise) begin
			bitCnt_reg  <= bitCnt_reg + 3'd1;
			gotByte_reg <= (bitCnt_reg == 3'd7);
		end else if (state_reg == TSC_SEND && sclFall) begin
			bitCnt_reg  <= bitCnt_reg + 3'd1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			shift_reg <= 8'h00;
		end else if (state_reg == TSC_RECV && sclRise) begin
			shift_reg <= {shift_reg[6:0], sdaS};
		end
	end

	// Position in the transfer and direction
	always_ff @(posedge clock) begin
		if (srst || startCond) begin
			byteIdx_reg  <= 2'd0;
			readMode_reg <= 1'b0;
		end else if (addrByte) begin
			byteIdx_reg  <= 2'd1;
			readMode_reg <= rxByte[`TSC_ADDR_RW_BIT];
		end else if (dataByte && byteIdx_reg != 2'd3) begin
			byteIdx_reg  <= byteIdx_reg + 2'd1;
		end
	end

	// Command byte is kept across a repeated start for the read phase
	always_ff @(posedge clock) begin
		if (srst) begin
			cmd_reg <= 8'h00;
		end else if (cmdByte) begin
			cmd_reg <= rxByte;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			msbHold_reg <= 8'h00;
		end else if (wrByte1) begin
			msbHold_reg <= rxByte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write side of limit and configuration access

	logic [15:0] highLimit_reg;
	logic [15:0] lowLimit_reg;
	logic [1:0]  cfg_reg;
	logic [20:0] nvCnt_reg;

	wire isHigh   = (cmd_reg == `TSC_CMD_HIGH_LIMIT);
	wire isLow    = (cmd_reg == `TSC_CMD_LOW_LIMIT);
	wire isConfig = (cmd_reg == `TSC_CMD_CONFIG);
	wire nvStart  = (wrByte2 && (isHigh || isLow)) || (wrByte1 && isConfig);

	always_ff @(posedge clock) begin
		if (srst) begin
			highLimit_reg <= `TSC_LIMIT_RESET;
			lowLimit_reg  <= `TSC_LIMIT_RESET;
		end else if (wrByte2 && isHigh) begin
			highLimit_reg <= {msbHold_reg, rxByte};
		end else if (wrByte2 && isLow) begin
			lowLimit_reg  <= {msbHold_reg, rxByte};
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_reg <= `TSC_CFG_RESET;
		end else if (wrByte1 && isConfig) begin
			cfg_reg <= {rxByte[`TSC_CFG_POL_BIT], rxByte[`TSC_CFG_ONESHOT_BIT]};
		end
	end

	// Nonvolatile write busy window
	always_ff @(posedge clock) begin
		if (srst) begin
			nvCnt_reg <= 21'd0;
		end else if (nvStart) begin
			nvCnt_reg <= 21'(NV_WRITE_CYCLES);
		end else if (nvCnt_reg != 21'd0) begin
			nvCnt_reg <= nvCnt_reg - 21'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion control

	logic convActive_reg;
	logic stopReq_reg;
	logic pendStart_reg;
	logic pendStop_reg;
	logic doneFlag_reg;
	logic [15:0] temp_reg;

	wire cmdTakes = startCond || stopCond;

	// Start and stop take no data; the command is armed until the bus ends it
	always_ff @(posedge clock) begin
		if (srst || cmdTakes) begin
			pendStart_reg <= 1'b0;
			pendStop_reg  <= 1'b0;
		end else if (cmdByte) begin
			pendStart_reg <= (rxByte == `TSC_CMD_START_CONV);
			pendStop_reg  <= (rxByte == `TSC_CMD_STOP_CONV);
		end
	end

	wire doStart = cmdTakes && pendStart_reg;
	wire doStop  = cmdTakes && pendStop_reg && convActive_reg;

	always_ff @(posedge clock) begin
		if (srst) begin
			convActive_reg <= 1'b0;
			stopReq_reg    <= 1'b0;
		end else if (doStart) begin
			convActive_reg <= 1'b1;
			stopReq_reg    <= 1'b0;
		end else if (convDone && (cfg_reg[0] || stopReq_reg || doStop)) begin
			convActive_reg <= 1'b0;
			stopReq_reg    <= 1'b0;
		end else if (doStop) begin
			stopReq_reg    <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			temp_reg     <= `TSC_TEMP_RESET;
			doneFlag_reg <= 1'b0;
		end else if (convDone && convActive_reg) begin
			temp_reg     <= tempResult;
			doneFlag_reg <= 1'b1;
		end else if (doStart) begin
			doneFlag_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read side

	wire [7:0] cfgRead = {doneFlag_reg, 2'b00, (nvCnt_reg != 21'd0), 2'b00, cfg_reg[1], cfg_reg[0]};
	logic [7:0] rdData;

	always_comb begin
		rdData = `TSC_IDLE_BYTE;
		case (cmd_reg)
			`TSC_CMD_READ_TEMP:    rdData = rdIdx_reg ? temp_reg[7:0] : temp_reg[15:8];
			`TSC_CMD_HIGH_LIMIT:   rdData = rdIdx_reg ? highLimit_reg[7:0] : highLimit_reg[15:8];
			`TSC_CMD_LOW_LIMIT:    rdData = rdIdx_reg ? lowLimit_reg[7:0] : lowLimit_reg[15:8];
			`TSC_CMD_CONFIG:       rdData = rdIdx_reg ? `TSC_IDLE_BYTE : cfgRead;
			`TSC_CMD_READ_COUNTER: rdData = rdIdx_reg ? `TSC_IDLE_BYTE : countRemain;
			`TSC_CMD_READ_SLOPE:   rdData = rdIdx_reg ? `TSC_IDLE_BYTE : countPerC;
			default:               rdData = `TSC_IDLE_BYTE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst || startCond) begin
			rdIdx_reg <= 1'b0;
		end else if (sendEnd) begin
			// Second byte is selected before the master ack reloads the shifter
			rdIdx_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst || startCond || mackEnd) begin
			mackOk_reg <= 1'b0;
		end else if (state_reg == TSC_MACK && sclRise) begin
			mackOk_reg <= ~sdaS;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			txByte_reg <= 8'h00;
		end else if (loadTx) begin
			txByte_reg <= rdData;
		end else if (state_reg == TSC_SEND && sclFall) begin
			txByte_reg <= {txByte_reg[6:0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-drain data pin: only ever pulled low

	wire ackDrive = ackAddr || (byteEnd && !addrByte && !readMode_reg);
	wire sendBit  = (state_next == TSC_SEND) && !(startCond || stopCond);

	always_ff @(posedge clock) begin
		if (srst || startCond || stopCond) begin
			sdaOe_reg <= 1'b0;
		end else if (ackDrive) begin
			sdaOe_reg <= 1'b1;
		end else if (loadTx) begin
			sdaOe_reg <= ~rdData[7];
		end else if (sendEnd || ackEnd || mackEnd) begin
			sdaOe_reg <= 1'b0;
		end else if (sendBit && sclFall) begin
			sdaOe_reg <= ~txByte_reg[6];
		end
	end

	assign sdaOut      = 1'b0;
	assign sdaOe       = sdaOe_reg;
	assign convEnable  = convActive_reg;
	assign highLimit   = highLimit_reg;
	assign lowLimit    = lowLimit_reg;
	assign cfgPolarity = cfg_reg[1];
	assign cfgOneShot  = cfg_reg[0];
	assign nvBusy      = (nvCnt_reg != 21'd0);

endmodule

// ==== tsc_command_decoder_props.sv ====
`timescale 1ns/10ps

module tsc_command_decoder_props #(
	parameter int NV_WRITE_CYCLES = 20
) (
	input wire logic        clock,
	input wire logic        srst,
	input wire logic        sclIn,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic        convDone,
	input wire logic        convEnable,
	input wire logic [15:0] highLimit,
	input wire logic [15:0] lowLimit,
	input wire logic        cfgPolarity,
	input wire logic        cfgOneShot,
	input wire logic        nvBusy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	logic [31:0] busyCnt_reg;
	logic        wasRst_reg;

	// Masks the edges that reset itself causes
	always_ff @(posedge clock) begin
		wasRst_reg <= srst;
		if (srst || !nvBusy) begin
			busyCnt_reg <= '0;
		end else begin
			busyCnt_reg <= busyCnt_reg + 32'h0000_0001;
		end
	end

	////////////////////////////////////////
	a_pin_open_drain: assert property (sdaOut == 1'b0)
		else $error("sdaOut not low");
	a_ack_rise_low: assert property ($rose(sdaOe) |-> !sclIn)
		else $error("sdaOe rose with SCL high");
	a_ack_fall_low: assert property (!wasRst_reg && $fell(sdaOe) |-> !sclIn)
		else $error("sdaOe fell with SCL high");
	a_conv_on_bus: assert property ($rose(convEnable) |-> sclIn)
		else $error("conversion began outside bus condition");
	a_conv_off_done: assert property (!wasRst_reg && $fell(convEnable) |-> $past(convDone) || $past(convDone, 2))
		else $error("conversion stopped without done");
	a_limit_busy: assert property (!wasRst_reg && ($changed(highLimit) || $changed(lowLimit)) |-> ##[0:8] nvBusy)
		else $error("limit stored without busy");
	a_cfg_busy: assert property (!wasRst_reg && $changed({cfgPolarity, cfgOneShot}) |-> ##[0:8] nvBusy)
		else $error("config stored without busy");
	a_nv_length: assert property (!wasRst_reg && $fell(nvBusy) |-> busyCnt_reg == 32'(NV_WRITE_CYCLES))
		else $error("busy length wrong");
endmodule

bind tsc_command_decoder tsc_command_decoder_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) uProps (
	.clock(clock),
	.srst(srst),
	.sclIn(sclIn),
	.sdaOut(sdaOut),
	.sdaOe(sdaOe),
	.convDone(convDone),
	.convEnable(convEnable),
	.highLimit(highLimit),
	.lowLimit(lowLimit),
	.cfgPolarity(cfgPolarity),
	.cfgOneShot(cfgOneShot),
	.nvBusy(nvBusy)
);

// ==== tsc_bus_master.sv ====
`timescale 1ns/10ps

module tsc_bus_master (
	input  wire logic clock,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask

	// SDA moves 2 clocks into SCL low so the slave never sees it move with SCL high
	task automatic bitx(input logic b, output logic r);
		w(2);
		sda <= b;
		w(6);
		scl <= 1'b1;
		w(4);
		r = sdaWire;
		w(4);
		scl <= 1'b0;
	endtask

	task automatic start();
		sda <= 1'b1;
		w(6);
		scl <= 1'b1;
		w(8);
		sda <= 1'b0;
		w(8);
		scl <= 1'b0;
	endtask

	task automatic stop();
		w(2);
		sda <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(8);
		sda <= 1'b1;
		w(8);
	endtask

	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r[i]);
		end
		bitx(last, ack);
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps

module tb;
	logic        clock;
	logic        srst;
	logic        scl;
	logic        sdaM;
	wire logic   sdaWire;
	logic        convDone;
	logic [2:0]  addrSel;
	logic [15:0] tempResult;
	logic [7:0]  countRemain;
	logic [7:0]  countPerC;
	logic        sdaOut;
	logic        sdaOe;
	logic        convEnable;
	logic [15:0] highLimit;
	logic [15:0] lowLimit;
	logic        cfgPolarity;
	logic        cfgOneShot;
	logic        nvBusy;
	logic [7:0]  rd;
	logic        ak;
	logic [15:0] v;
	int          n_mismatch = 0;
	int          checked = 0;

	// Pull-up wire: low when either party pulls
	assign sdaWire = sdaM & ~(sdaOe & ~sdaOut);

	tsc_command_decoder #(.NV_WRITE_CYCLES(20)) dut (
		.clock(clock),
		.srst(srst),
		.sclIn(scl),
		.sdaIn(sdaWire),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.addrSel(addrSel),
		.convDone(convDone),
		.tempResult(tempResult),
		.countRemain(countRemain),
		.countPerC(countPerC),
		.convEnable(convEnable),
		.highLimit(highLimit),
		.lowLimit(lowLimit),
		.cfgPolarity(cfgPolarity),
		.cfgOneShot(cfgOneShot),
		.nvBusy(nvBusy)
	);

	tsc_bus_master m (
		.clock(clock),
		.sdaWire(sdaWire),
		.scl(scl),
		.sda(sdaM)
	);

	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic [7:0] d);
		m.xfer(d, 1'b1, rd, ak);
		chk(16'(ak), 16'h0);
	endtask

	task automatic hdr(input logic [7:0] c);
		m.start();
		wb({4'h9, addrSel, 1'b0});
		wb(c);
	endtask

	task automatic rdc(input logic [7:0] c, input int n, output logic [15:0] r);
		hdr(c);
		m.start();
		wb({4'h9, addrSel, 1'b1});
		r = '0;
		for (int i = n; i > 0; i--) begin
			m.xfer(8'hFF, i == 1, rd, ak);
			r = {r[7:0], rd};
		end
		m.stop();
	endtask

	task automatic pulse(input logic [15:0] t);
		tempResult <= t;
		convDone <= 1'b1;
		@(posedge clock);
		convDone <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task automatic cmd(input logic [7:0] c);
		hdr(c);
		m.stop();
	endtask

	// Byte times keep each stored write far more than 20 clocks apart
	task automatic t_cfg();
		hdr(8'hAC);
		wb(8'h02);
		chk(16'(nvBusy), 16'h1);
		hdr(8'hA1);
		wb(8'h28);
		wb(8'h00);
		hdr(8'hA2);
		wb(8'h0A);
		wb(8'h00);
		m.stop();
		chk(16'({cfgPolarity, cfgOneShot}), 16'h2);
		chk(highLimit, 16'h2800);
		chk(lowLimit, 16'h0A00);
		rdc(8'hA1, 2, v);
		chk(v, 16'h2800);
		rdc(8'hAC, 1, v);
		chk(v & 16'h0013, 16'h0002);
		$display("t_cfg done");
	endtask

	task automatic t_conv();
		hdr(8'hEE);
		chk(16'(convEnable), 16'h0);
		m.stop();
		chk(16'(convEnable), 16'h1);
		pulse(16'h1980);
		rdc(8'hAA, 2, v);
		chk(v, 16'h1980);
		cmd(8'h22);
		chk(16'(convEnable), 16'h1);
		pulse(16'h1A00);
		chk(16'(convEnable), 16'h0);
		cmd(8'h22);
		chk(16'(convEnable), 16'h0);
		rdc(8'hAA, 2, v);
		chk(v, 16'h1A00);
		cmd(8'hEE);
		chk(16'(convEnable), 16'h1);
		$display("t_conv done");
	endtask

	// One start per reading in one-shot mode
	task automatic t_one();
		hdr(8'hAC);
		wb(8'h01);
		m.stop();
		pulse(16'h0400);
		chk(16'(convEnable), 16'h0);
		repeat (2) begin
			cmd(8'hEE);
			chk(16'(convEnable), 16'h1);
			pulse(16'h0400);
			chk(16'(convEnable), 16'h0);
		end
		$display("t_one done");
	endtask

	task automatic t_neg();
		for (int i = 0; i < 2; i++) begin
			m.start();
			m.xfer(i ? {4'h8, addrSel, 1'b0} : {4'h9, addrSel ^ 3'h2, 1'b0}, 1'b1, rd, ak);
			chk(16'(ak), 16'h1);
			m.stop();
		end
		hdr(8'h55);
		wb(8'h12);
		m.stop();
		chk(highLimit, 16'h2800);
		chk(lowLimit, 16'h0A00);
		chk(16'({convEnable, cfgPolarity, cfgOneShot}), 16'h1);
		rdc(8'hA8, 1, v);
		chk(v, 16'h003C);
		rdc(8'hA9, 1, v);
		chk(v, 16'h0050);
		$display("t_neg done");
	endtask

	task automatic tally_and_finish();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial begin
		repeat (40000) @(posedge clock);
		n_mismatch++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		srst = 1'b1;
		convDone = 1'b0;
		tempResult = 16'h0000;
		countRemain = 8'h3C;
		countPerC = 8'h50;
		addrSel = 3'h5;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		t_cfg();
		t_conv();
		t_one();
		t_neg();
		tally_and_finish();
	end
endmodule
